/* logic/pmt_pkg.sv */
// package: register map, field layout and timing constants of the period match timer
package pmt_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_COUNT   = 8'h04;
  localparam logic [7:0] ADDR_PERIOD  = 8'h08;
  localparam logic [7:0] ADDR_FLAG    = 8'h0c;
  localparam logic [7:0] ADDR_ENABLE  = 8'h10;
  // timer_control fields and the flag/enable register bit
  localparam int POST_LSB  = 3;
  localparam int POST_MSB  = 6;
  localparam int RUN_BIT   = 2;
  localparam int PRE_LSB   = 0;
  localparam int PRE_MSB   = 1;
  localparam int FLAG_BIT  = 0;
  // reset values and control write mask
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] PERIOD_RESET  = 8'hff;
  localparam logic [6:0] CONTROL_MASK  = 7'h7f;
  // prescale terminal counts (divide minus one)
  localparam logic [5:0] PRE_TC_1  = 6'h00;
  localparam logic [5:0] PRE_TC_4  = 6'h03;
  localparam logic [5:0] PRE_TC_16 = 6'h0f;
  localparam logic [5:0] PRE_TC_64 = 6'h3f;
  // instruction clock is the system clock divided by four
  localparam int CLOCK_MHZ     = 100;
  localparam int INSTR_DIV     = 4;
  localparam logic [1:0] INSTR_TC = 2'(INSTR_DIV - 1);
  // unmapped read data
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage

/* logic/pmt_prescaler.sv */
// prescaler: divides instruction-clock ticks by 1, 4, 16 or 64
`timescale 1ns/10ps
`default_nettype none
module pmt_prescaler (
  input  wire logic       i_clock,
  input  wire logic       i_srst,
  input  wire logic       i_clear,
  input  wire logic       i_tick,
  input  wire logic [1:0] i_select,
  output logic            o_tick
);
  logic [5:0] count_reg;
  logic [5:0] count_next;
  logic [5:0] terminal;

  always_comb begin
    unique case (i_select)
      2'h0: terminal = pmt_pkg::PRE_TC_1;
      2'h1: terminal = pmt_pkg::PRE_TC_4;
      2'h2: terminal = pmt_pkg::PRE_TC_16;
      2'h3: terminal = pmt_pkg::PRE_TC_64;
    endcase
  end

  assign o_tick = i_tick && (count_reg >= terminal);

  always_comb begin
    count_next = count_reg;
    if (i_clear) begin
      count_next = 6'h00;
    end else if (o_tick) begin
      count_next = 6'h00;
    end else if (i_tick) begin
      count_next = count_reg + 6'h01;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      count_reg <= 6'h00;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule
`default_nettype wire

/* logic/pmt_timer.sv */
// top: period match timer with prescaler, postscaler, apb registers and interrupt
//
// Functional notes
// (RULE_01) count increments from zero per prescaled tick
// (RULE_02) count equals period: pulse, then clear
// (RULE_03) reset clears count, period to ones
// (RULE_04) count/control writes clear pre/postscalers
// (RULE_05) matches feed postscaler; terminal sets flag
// (RULE_06) interrupt only when match enable set
// (RULE_07) postscale ratio code n gives 1:(n+1)
// (RULE_08) prescale 1, 4, 16 or 64
// (RULE_09) counts only while run bit set
// (RULE_10) control bit 7 reads zero
// (RULE_11) unscaled match pulse to capture unit
// (RULE_12) match output serves as shift clock
// (RULE_13) sleep stops counting, keeps registers
// (RULE_14) count and period readable and writable
// (RULE_15) flag set by hardware, software clears
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module pmt_timer (
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic        i_sleep,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic [31:0]      o_prdata,
  output logic             o_match_pulse,
  output logic             o_shift_clock,
  output logic             o_irq
);
  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic bus_write;
  logic bus_read;
  logic wr_control;
  logic wr_count;
  logic wr_period;
  logic wr_flag;
  logic wr_enable;
  logic addr_ok;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    return addr == reg_addr;
  endfunction

  assign addr_ok = hit(i_paddr, pmt_pkg::ADDR_CONTROL) || hit(i_paddr, pmt_pkg::ADDR_COUNT)
                || hit(i_paddr, pmt_pkg::ADDR_PERIOD) || hit(i_paddr, pmt_pkg::ADDR_FLAG)
                || hit(i_paddr, pmt_pkg::ADDR_ENABLE);
  assign bus_write  = i_psel && i_penable && i_pwrite && i_pstrb[0];
  assign bus_read   = i_psel && !i_pwrite;
  assign wr_control = bus_write && hit(i_paddr, pmt_pkg::ADDR_CONTROL);
  assign wr_count   = bus_write && hit(i_paddr, pmt_pkg::ADDR_COUNT);
  assign wr_period  = bus_write && hit(i_paddr, pmt_pkg::ADDR_PERIOD);
  assign wr_flag    = bus_write && hit(i_paddr, pmt_pkg::ADDR_FLAG);
  assign wr_enable  = bus_write && hit(i_paddr, pmt_pkg::ADDR_ENABLE);

  // zero wait states; unmapped addresses answer with an error
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [6:0] control_reg;
  logic [6:0] control_next;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] period_reg;
  logic [7:0] period_next;
  logic       flag_reg;
  logic       flag_next;
  logic       enable_reg;
  logic       enable_next;
  logic [1:0] instr_reg;
  logic [1:0] instr_next;
  logic [3:0] post_reg;
  logic [3:0] post_next;
  logic       match_pend_reg;
  logic       match_pend_next;
  logic       shift_reg;
  logic       shift_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  logic       scaler_clear;
  logic       instr_tick;
  logic       pre_tick;
  logic       match;
  logic       post_terminal;
  logic       running;

  // sleep stops the timer without touching its contents
  assign running      = control_reg[pmt_pkg::RUN_BIT] && !i_sleep; // RULE_09 RULE_13
  assign scaler_clear = wr_count || wr_control; // RULE_04
  assign instr_tick   = running && (instr_reg == pmt_pkg::INSTR_TC); // RULE_01
  assign match        = (count_reg == period_reg); // RULE_02

  pmt_prescaler i_pmt_prescaler (
    .i_clock  (i_clock),
    .i_srst   (i_srst),
    .i_clear  (scaler_clear),
    .i_tick   (instr_tick),
    .i_select (control_reg[pmt_pkg::PRE_MSB:pmt_pkg::PRE_LSB]), // RULE_08
    .o_tick   (pre_tick)
  );

  // one match event per prescaled tick at which count equals period
  logic match_event;
  assign match_event   = pre_tick && match;
  assign post_terminal = match_event
                      && (post_reg == control_reg[pmt_pkg::POST_MSB:pmt_pkg::POST_LSB]); // RULE_07

  ////////////////////////////////////////////////////////////////////////////
  // control register: postscale, run and prescale fields
  always_comb begin
    control_next = control_reg;
    if (wr_control) begin
      control_next = i_pwdata[6:0] & pmt_pkg::CONTROL_MASK;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      control_reg <= pmt_pkg::CONTROL_RESET[6:0];
    end else begin
      control_reg <= control_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // period register
  always_comb begin
    period_next = period_reg;
    if (wr_period) begin
      period_next = i_pwdata[7:0]; // RULE_14
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      period_reg <= pmt_pkg::PERIOD_RESET; // RULE_03
    end else begin
      period_reg <= period_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt enable
  always_comb begin
    enable_next = enable_reg;
    if (wr_enable) begin
      enable_next = i_pwdata[pmt_pkg::FLAG_BIT];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      enable_reg <= 1'b0;
    end else begin
      enable_reg <= enable_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction clock phase: register writes leave it alone, so tick spacing stays even
  always_comb begin
    instr_next = instr_reg;
    if (running) begin
      instr_next = instr_reg + 2'h1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      instr_reg <= 2'h0;
    end else begin
      instr_reg <= instr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count: write wins, otherwise clear after match, otherwise increment
  always_comb begin
    count_next = count_reg;
    if (wr_count) begin
      count_next = i_pwdata[7:0]; // RULE_14
    end else if (match_event) begin
      count_next = 8'h00; // RULE_02
    end else if (pre_tick) begin
      count_next = count_reg + 8'h01; // RULE_01
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      count_reg <= pmt_pkg::COUNT_RESET; // RULE_03
    end else begin
      count_reg <= count_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // postscaler: counts unscaled matches
  always_comb begin
    post_next = post_reg;
    if (scaler_clear) begin
      post_next = 4'h0; // RULE_04
    end else if (post_terminal) begin
      post_next = 4'h0;
    end else if (match_event) begin
      post_next = post_reg + 4'h1; // RULE_05
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      post_reg <= 4'h0; // RULE_04
    end else begin
      post_reg <= post_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // writing one clears the flag; a new terminal event in that cycle wins
  always_comb begin
    flag_next = flag_reg;
    if (wr_flag && i_pwdata[pmt_pkg::FLAG_BIT]) begin
      flag_next = 1'b0; // RULE_15
    end
    if (post_terminal && !scaler_clear) begin
      flag_next = 1'b1; // RULE_05 RULE_15
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unscaled match pulse and shift clock, both from flip-flops
  always_comb begin
    match_pend_next = 1'b0;
    shift_next      = shift_reg;
    if (match_event) begin
      match_pend_next = 1'b1; // RULE_11
      shift_next      = !shift_reg; // RULE_12
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      match_pend_reg <= 1'b0;
      shift_reg      <= 1'b0;
    end else begin
      match_pend_reg <= match_pend_next;
      shift_reg      <= shift_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data: captured in the setup cycle, held through the access cycle
  always_comb begin
    rdata_next = pmt_pkg::READ_ZERO;
    if (bus_read && !i_penable) begin
      if (hit(i_paddr, pmt_pkg::ADDR_CONTROL)) begin
        rdata_next = {25'h0, control_reg}; // RULE_10
      end else if (hit(i_paddr, pmt_pkg::ADDR_COUNT)) begin
        rdata_next = {24'h0, count_reg}; // RULE_14
      end else if (hit(i_paddr, pmt_pkg::ADDR_PERIOD)) begin
        rdata_next = {24'h0, period_reg}; // RULE_14
      end else if (hit(i_paddr, pmt_pkg::ADDR_FLAG)) begin
        rdata_next = {31'h0, flag_reg};
      end else if (hit(i_paddr, pmt_pkg::ADDR_ENABLE)) begin
        rdata_next = {31'h0, enable_reg};
      end
    end else if (bus_read) begin
      rdata_next = rdata_reg;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rdata_reg <= pmt_pkg::READ_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_prdata      = rdata_reg;
  assign o_match_pulse = match_pend_reg; // RULE_11
  assign o_shift_clock = shift_reg; // RULE_12
  assign o_irq         = flag_reg && enable_reg; // RULE_06
endmodule
`default_nettype wire

/* verif/period_match_timer_tb.sv */
// testbench: register, prescale, postscale, interrupt and sleep checks
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
  $display("Error %0t: got %h expected %h", $time, a, e); end end
module period_match_timer_tb;
  logic        i_clock = 0, i_srst = 1, i_sleep = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h00000000, o_prdata, r, held;
  logic [3:0]  i_pstrb = 4'hf;
  logic        o_pready, o_pslverr, o_match_pulse, o_shift_clock, o_irq, err, zero = 0;
  logic [15:0] pulses, toggles, gap;
  int          miscompares = 0, comparisons = 0;
  logic [7:0]  ad [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  logic [7:0]  rv [5] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
  always #5 i_clock = ~i_clock;
  pmt_timer i_pmt_timer (.*);
  pmt_pwm_partner i_pmt_pwm_partner (.i_clock(i_clock), .i_zero(zero),
    .i_match_pulse(o_match_pulse), .i_shift_clock(o_shift_clock),
    .o_pulses(pulses), .o_toggles(toggles), .o_gap(gap));
  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock) {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, 24'h000000, d};
    @(posedge i_clock) i_penable <= 1'b1;
    do @(posedge i_clock); while (o_pready !== 1'b1);
    r = o_prdata;
    err = o_pslverr;
    {i_psel, i_penable} <= 2'b00;
  endtask
  task automatic restart(input logic [7:0] per, input logic [7:0] ctl);
    apb(1, pmt_pkg::ADDR_CONTROL, ctl & 8'hfb);
    apb(1, pmt_pkg::ADDR_COUNT, 8'h00);
    apb(1, pmt_pkg::ADDR_PERIOD, per);
    apb(1, pmt_pkg::ADDR_FLAG, 8'h01);
    @(posedge i_clock) zero <= 1'b1;
    @(posedge i_clock) zero <= 1'b0;
    apb(1, pmt_pkg::ADDR_CONTROL, ctl);
  endtask
  task automatic results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge i_clock);
    miscompares++;
    results();
  end
  initial begin
    repeat (12) @(posedge i_clock);
    i_srst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      apb(0, ad[i], 8'h00);
      `CHK(r, {24'h000000, rv[i]})
    end
    apb(1, pmt_pkg::ADDR_COUNT, 8'h37);
    apb(1, pmt_pkg::ADDR_CONTROL, 8'hfb);
    apb(0, pmt_pkg::ADDR_CONTROL, 8'h00);
    `CHK(r, 32'h0000007b)
    apb(0, pmt_pkg::ADDR_COUNT, 8'h00);
    `CHK(r, 32'h00000037)
    apb(1, pmt_pkg::ADDR_PERIOD, 8'h5a);
    apb(0, pmt_pkg::ADDR_PERIOD, 8'h00);
    `CHK(r, 32'h0000005a)
    i_pstrb <= 4'he;
    apb(1, pmt_pkg::ADDR_PERIOD, 8'h11);
    i_pstrb <= 4'hf;
    apb(0, pmt_pkg::ADDR_PERIOD, 8'h00);
    `CHK(r, 32'h0000005a)
    apb(0, 8'h14, 8'h00);
    `CHK({err, r}, {1'b1, 32'h00000000})
    for (int p = 0; p < 4; p++) begin
      restart(8'h01, {6'h01, 2'(p)});
      for (int k = 0; k < 4000 && pulses < 16'h0003; k++) @(posedge i_clock);
      `CHK(gap, 16'(8 << (2 * p)))
    end
    apb(1, pmt_pkg::ADDR_ENABLE, 8'h01);
    for (int n = 0; n < 16; n++) begin
      restart(8'h00, {1'b0, 4'(n), 3'b100});
      for (int k = 0; k < 200 && o_irq !== 1'b1; k++) @(posedge i_clock);
      @(posedge i_clock);
      `CHK(pulses, 16'(n + 1))
      `CHK(toggles, 16'(n + 1))
    end
    apb(1, pmt_pkg::ADDR_CONTROL, 8'h00);
    apb(0, pmt_pkg::ADDR_FLAG, 8'h00);
    `CHK(r, 32'h00000001)
    apb(1, pmt_pkg::ADDR_ENABLE, 8'h00);
    @(posedge i_clock);
    `CHK(o_irq, 1'b0)
    apb(1, pmt_pkg::ADDR_FLAG, 8'h01);
    apb(0, pmt_pkg::ADDR_FLAG, 8'h00);
    `CHK(r, 32'h00000000)
    restart(8'hff, 8'h04);
    @(posedge i_clock) i_sleep <= 1'b1;
    apb(0, pmt_pkg::ADDR_COUNT, 8'h00);
    held = r;
    repeat (40) @(posedge i_clock);
    apb(0, pmt_pkg::ADDR_COUNT, 8'h00);
    `CHK(r, held)
    results();
  end
endmodule
`default_nettype wire

/* verif/pmt_pwm_partner.sv */
// partner: capture unit and serial port side, counting match pulses and shift-clock edges
`timescale 1ns/10ps
`default_nettype none
module pmt_pwm_partner (
  input  wire logic        i_clock,
  input  wire logic        i_zero,
  input  wire logic        i_match_pulse,
  input  wire logic        i_shift_clock,
  output logic      [15:0] o_pulses,
  output logic      [15:0] o_toggles,
  output logic      [15:0] o_gap
);
  logic [15:0] since;
  logic        prev;
  // the pwm time base runs on every unscaled match
  always_ff @(posedge i_clock) begin
    prev <= i_shift_clock;
    since <= i_match_pulse ? 16'h0000 : since + 16'h0001;
    if (i_zero) begin
      o_pulses <= 16'h0000;
      o_toggles <= 16'h0000;
    end else begin
      o_pulses <= o_pulses + 16'(i_match_pulse);
      o_toggles <= o_toggles + 16'(i_shift_clock != prev);
      if (i_match_pulse) o_gap <= since + 16'h0001;
    end
  end
endmodule
`default_nettype wire

/* verif/pmt_timer_assertions.sv */
// checker: port-level properties of the period match timer
`timescale 1ns/10ps
`default_nettype none
module pmt_timer_assertions (
  input wire logic        i_clock,
  input wire logic        i_srst,
  input wire logic        i_sleep,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0]  i_pstrb,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic [31:0] o_prdata,
  input wire logic        o_match_pulse,
  input wire logic        o_shift_clock,
  input wire logic        o_irq
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  logic acc;
  logic mapped;
  assign acc = i_psel && i_penable;
  assign mapped = i_paddr inside {pmt_pkg::ADDR_CONTROL, pmt_pkg::ADDR_COUNT,
    pmt_pkg::ADDR_PERIOD, pmt_pkg::ADDR_FLAG, pmt_pkg::ADDR_ENABLE};
  ////////////////////////////////////////////////////////////////////////////
  property p_reset_quiet; $past(i_srst) |-> !o_match_pulse && !o_irq && !o_shift_clock; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  // one instruction tick per four clocks, so matches sit at least four apart
  property p_pulse_gap; o_match_pulse |=> !o_match_pulse [*3]; endproperty
  a_pulse_gap: assert property (p_pulse_gap) else $error("match pulses too close");
  property p_sleep_hold; $past(i_sleep) |-> !o_match_pulse; endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("match while asleep");
  property p_run_off;
    acc && i_pwrite && i_pstrb[0] && i_paddr == pmt_pkg::ADDR_CONTROL && !i_pwdata[2]
      |=> ##1 !o_match_pulse [*8];
  endproperty
  a_run_off: assert property (p_run_off) else $error("match with timer off");
  property p_mask;
    acc && i_pwrite && i_pstrb[0] && i_paddr == pmt_pkg::ADDR_ENABLE && !i_pwdata[0] |=> !o_irq;
  endproperty
  a_mask: assert property (p_mask) else $error("interrupt while masked");
  property p_ctrl_b7; acc && !i_pwrite && i_paddr == pmt_pkg::ADDR_CONTROL |-> !(|o_prdata[31:7]);
  endproperty
  a_ctrl_b7: assert property (p_ctrl_b7) else $error("control bit 7 not zero");
  property p_upper; acc && !i_pwrite |-> o_prdata[31:8] == 24'h000000 && o_pready; endproperty
  a_upper: assert property (p_upper) else $error("read upper bits set");
  property p_err; acc |-> o_pslverr == !mapped; endproperty
  a_err: assert property (p_err) else $error("slave error wrong");
  property p_err_rd; acc && !mapped |-> o_prdata == pmt_pkg::READ_ZERO; endproperty
  a_err_rd: assert property (p_err_rd) else $error("unmapped read not zero");
  c_irq: cover property (o_irq);
  c_pulse: cover property (o_match_pulse);
  c_err: cover property (acc && o_pslverr);
endmodule
bind pmt_timer pmt_timer_assertions i_pmt_timer_assertions (.*);
`default_nettype wire
